/* File: src/lsg_map.vh */
`ifndef LSG_MAP_VH
`define LSG_MAP_VH

// ============================================================
// Register offsets on the register port
`define LSG_ADDR_W            8
`define LSG_OFF_CRC_CNT_LO    8'h0a
`define LSG_OFF_CRC_CNT_HI    8'h0b
`define LSG_OFF_STATUS        8'h0c
`define LSG_OFF_PIN0_CFG      8'h0d

// ============================================================
// Field positions
`define LSG_ST_LINK_LOST      4
`define LSG_ST_BIST_ERR       3
`define LSG_ST_TMDS_CLK       2
`define LSG_ST_NORM_ERR       1
`define LSG_ST_LINK_DET       0
`define LSG_CFG_REV_HI        7
`define LSG_CFG_REV_LO        4
`define LSG_CFG_OUT_VAL       3
`define LSG_CFG_MODE_HI       2
`define LSG_CFG_MODE_LO       0

// ============================================================
// Pin modes (bit 0 clear means high impedance)
`define LSG_MODE_OUT_LOCAL    3'h1
`define LSG_MODE_INPUT        3'h3
`define LSG_MODE_REMOTE_HOLD  3'h5
`define LSG_MODE_REMOTE_DFLT  3'h7

// ============================================================
// Reset values and sizes
`define LSG_RST_MODE          3'h0
`define LSG_RST_OUT_VAL       1'b0
`define LSG_RST_CNT           16'h0000
`define LSG_CNT_MAX           16'hffff
`define LSG_NUM_PORTS         2
// Revision value is arbitrary
`define LSG_REVISION_ID       4'h1

`endif

/* File: src/lsg_port_status.v */
`timescale 1ns/1ps
`default_nettype none
`include "lsg_map.vh"

module lsg_port_status (
   // Clock and reset
   input  wire        core_clk,
   input  wire        resetn,
   // Controls
   input  wire        err_reset,
   input  wire        bist_restart,
   // Link side
   input  wire        link_det_pin,
   input  wire        frame_crc_err,
   input  wire        bist_active,
   // Status
   output reg  [15:0] crc_cnt_r,
   output reg         link_lost_r,
   output reg         bist_err_r,
   output reg         norm_err_r,
   output reg         link_up_r
);

   // ============================================================
   // Link detect synchroniser and agreement filter
   reg        det_s1_r;
   reg        det_s2_r;
   reg        det_s3_r;
   wire       link_drop;
   wire       crc_hit;

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         det_s1_r  <= 1'b0;
         det_s2_r  <= 1'b0;
         det_s3_r  <= 1'b0;
         link_up_r <= 1'b0;
      end else begin
         det_s1_r <= link_det_pin;
         det_s2_r <= det_s1_r;
         det_s3_r <= det_s2_r;
         if (det_s2_r == det_s3_r) begin
            link_up_r <= det_s3_r;
         end
      end
   end

   assign link_drop = link_up_r && (det_s2_r == det_s3_r) && !det_s3_r;
   // Errors only count while the link is up
   assign crc_hit   = frame_crc_err && link_up_r;

   // ============================================================
   // Counter and sticky flags; a set beats a clear in the same cycle
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         crc_cnt_r   <= `LSG_RST_CNT;
         link_lost_r <= 1'b0;
         bist_err_r  <= 1'b0;
         norm_err_r  <= 1'b0;
      end else begin
         if (err_reset) begin
            crc_cnt_r <= {15'h0000, crc_hit};
         end else if (crc_hit && crc_cnt_r != `LSG_CNT_MAX) begin
            crc_cnt_r <= crc_cnt_r + 16'h0001;
         end
         if (link_drop) begin
            link_lost_r <= 1'b1;
         end else if (err_reset) begin
            link_lost_r <= 1'b0;
         end
         if (crc_hit && bist_active) begin
            bist_err_r <= 1'b1;
         end else if (link_drop || bist_restart || err_reset) begin
            bist_err_r <= 1'b0;
         end
         if (crc_hit && !bist_active) begin
            norm_err_r <= 1'b1;
         end else if (link_drop || err_reset) begin
            norm_err_r <= 1'b0;
         end
      end
   end

endmodule // lsg_port_status

`default_nettype wire

/* File: src/lsg_link_status_gpio_regs.v */
// Overview of operation
// - 16-bit CRC error count, two bytes, cleared
// - Port select shows second port's counters, flags
// - Sticky link-lost flag until error reset
// - Self-test CRC error flag, cleared three ways
// - Status bit 2 shows input clock present
// - Normal-traffic CRC error flag, cleared twice
// - Status bit 0 shows live link detect
// - Local value drives pin in local output
// - Mode decode: xx0 off, 001 out, 011 in
// - Mode 101 remote value, held on loss
// - Mode 111 remote value, local on loss
// - Port select steers pin configuration writes
`timescale 1ns/1ps
`default_nettype none
`include "lsg_map.vh"

module lsg_link_status_gpio_regs (
   // Clock and reset
   input  wire                    core_clk,
   input  wire                    resetn,
   // Register port
   input  wire [`LSG_ADDR_W-1:0]  reg_addr,
   input  wire                    reg_wr_en,
   input  wire [7:0]              reg_wr_data,
   input  wire                    reg_rd_en,
   output reg  [7:0]              reg_rd_data_r,
   output reg                     reg_rd_valid_r,
   // Controls held elsewhere in the map
   input  wire                    second_port_select,
   input  wire                    crc_err_reset,
   input  wire [1:0]              bist_restart,
   // Link side, per port (bit 1 is the second port)
   input  wire [1:0]              link_det_pin,
   input  wire [1:0]              frame_crc_err,
   input  wire [1:0]              bist_active,
   input  wire [1:0]              remote_pin_valid,
   input  wire [1:0]              remote_pin_value,
   // Video input
   input  wire                    tmds_clk_det_pin,
   // First-port pin
   input  wire                    pin_zero_in,
   output reg                     pin_zero_out_r,
   output reg                     pin_zero_oe_r,
   // Second-port pin
   input  wire                    second_port_pin_zero_in,
   output reg                     second_port_pin_zero_out_r,
   output reg                     second_port_pin_zero_oe_r,
   // Filtered pin levels sent to the remote end
   output reg  [1:0]              pin_level_to_remote_r,
   // Live link state
   output reg  [1:0]              link_up_out_r
);

   // ============================================================
   // Per-port status blocks
   wire [15:0] crc_cnt   [0:1];
   wire [1:0]  link_lost;
   wire [1:0]  bist_err;
   wire [1:0]  norm_err;
   wire [1:0]  link_up;
   wire [1:0]  pin_in_raw;

   assign pin_in_raw = {second_port_pin_zero_in, pin_zero_in};

   // One status block per link port; both share the error reset
   genvar p;
   generate
      for (p = 0; p < `LSG_NUM_PORTS; p = p + 1) begin : g_port
         lsg_port_status u_status (
            .core_clk      (core_clk),
            .resetn        (resetn),
            .err_reset     (crc_err_reset),
            .bist_restart  (bist_restart[p]),
            .link_det_pin  (link_det_pin[p]),
            .frame_crc_err (frame_crc_err[p]),
            .bist_active   (bist_active[p]),
            .crc_cnt_r     (crc_cnt[p]),
            .link_lost_r   (link_lost[p]),
            .bist_err_r    (bist_err[p]),
            .norm_err_r    (norm_err[p]),
            .link_up_r     (link_up[p])
         );
      end
   endgenerate

   // ============================================================
   // Input clock detect synchroniser
   reg tclk_s1_r;
   reg tclk_s2_r;
   reg tclk_s3_r;
   reg tmds_clk_ok_r;
   // Stages two and three must agree, so a one-cycle glitch is dropped

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tclk_s1_r     <= 1'b0;
         tclk_s2_r     <= 1'b0;
         tclk_s3_r     <= 1'b0;
         tmds_clk_ok_r <= 1'b0;
      end else begin
         tclk_s1_r <= tmds_clk_det_pin;
         tclk_s2_r <= tclk_s1_r;
         tclk_s3_r <= tclk_s2_r;
         if (tclk_s2_r == tclk_s3_r) begin
            tmds_clk_ok_r <= tclk_s3_r;
         end
      end
   end

   // ============================================================
   // Pin configuration, remote value, pin drive per port
   reg  [2:0] pin_mode_r   [0:1];
   reg        pin_outval_r [0:1];
   reg  [1:0] remote_val_r;
   reg  [1:0] pin_s1_r;
   reg  [1:0] pin_s2_r;
   reg  [1:0] pin_s3_r;
   wire       cfg_wr;

   // Only the pin register takes writes; count and status bytes ignore
   // them, and the revision nibble has no storage behind it
   assign cfg_wr = reg_wr_en && (reg_addr == `LSG_OFF_PIN0_CFG);

   generate
      for (p = 0; p < `LSG_NUM_PORTS; p = p + 1) begin : g_pin
         wire port_hit;
         reg  drv_val;
         reg  drv_en;

         assign port_hit = cfg_wr && (second_port_select == (p == 1));

         always @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               pin_mode_r[p]   <= `LSG_RST_MODE;
               pin_outval_r[p] <= `LSG_RST_OUT_VAL;
            end else if (port_hit) begin
               pin_mode_r[p]   <=
                  reg_wr_data[`LSG_CFG_MODE_HI:`LSG_CFG_MODE_LO];
               pin_outval_r[p] <= reg_wr_data[`LSG_CFG_OUT_VAL];
            end
         end

         // Remote value only follows while the link is up, so it holds
         always @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               remote_val_r[p] <= 1'b0;
            end else if (remote_pin_valid[p] && link_up[p]) begin
               remote_val_r[p] <= remote_pin_value[p];
            end
         end

         always @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               pin_s1_r[p]              <= 1'b0;
               pin_s2_r[p]              <= 1'b0;
               pin_s3_r[p]              <= 1'b0;
               pin_level_to_remote_r[p] <= 1'b0;
            end else begin
               pin_s1_r[p] <= pin_in_raw[p];
               pin_s2_r[p] <= pin_s1_r[p];
               pin_s3_r[p] <= pin_s2_r[p];
               // Level is offered only in input mode, else it holds
               if (pin_s2_r[p] == pin_s3_r[p] &&
                   pin_mode_r[p] == `LSG_MODE_INPUT) begin
                  pin_level_to_remote_r[p] <= pin_s3_r[p];
               end
            end
         end

         // Drive decode per mode
         always @* begin
            drv_val = 1'b0;
            drv_en  = 1'b0;
            if (pin_mode_r[p][0]) begin
               case (pin_mode_r[p])
                  `LSG_MODE_OUT_LOCAL: begin
                     drv_val = pin_outval_r[p];
                     drv_en  = 1'b1;
                  end
                  `LSG_MODE_INPUT: begin
                     drv_val = 1'b0;
                     drv_en  = 1'b0;
                  end
                  `LSG_MODE_REMOTE_HOLD: begin
                     drv_val = remote_val_r[p];
                     drv_en  = 1'b1;
                  end
                  `LSG_MODE_REMOTE_DFLT: begin
                     drv_val = link_up[p] ? remote_val_r[p]
                                          : pin_outval_r[p];
                     drv_en  = 1'b1;
                  end
                  // Even codes never get here; keeps the decode complete
                  default: begin
                     drv_val = 1'b0;
                     drv_en  = 1'b0;
                  end
               endcase
            end
         end

         // Registered drive, one flip-flop pair per pin
         if (p == 0) begin : g_drv0
            always @(posedge core_clk or negedge resetn) begin
               if (!resetn) begin
                  pin_zero_out_r <= 1'b0;
                  pin_zero_oe_r  <= 1'b0;
               end else begin
                  pin_zero_out_r <= drv_val;
                  pin_zero_oe_r  <= drv_en;
               end
            end
         end else begin : g_drv1
            always @(posedge core_clk or negedge resetn) begin
               if (!resetn) begin
                  second_port_pin_zero_out_r <= 1'b0;
                  second_port_pin_zero_oe_r  <= 1'b0;
               end else begin
                  second_port_pin_zero_out_r <= drv_val;
                  second_port_pin_zero_oe_r  <= drv_en;
               end
            end
         end
      end
   endgenerate

   // ============================================================
   // Live link state per port
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         link_up_out_r <= 2'b00;
      end else begin
         link_up_out_r <= link_up;
      end
   end

   // ============================================================
   // Read path
   reg  [7:0]  rd_nxt;
   wire [15:0] sel_cnt;
   wire        sel;

   // No latch between the count bytes; a carry between reads tears it
   // selected port view
   assign sel     = second_port_select;
   assign sel_cnt = sel ? crc_cnt[1] : crc_cnt[0];

   always @* begin
      rd_nxt = 8'h00;
      if (reg_addr == `LSG_OFF_CRC_CNT_LO) begin
         rd_nxt = sel_cnt[7:0];
      end else if (reg_addr == `LSG_OFF_CRC_CNT_HI) begin
         rd_nxt = sel_cnt[15:8];
      end else if (reg_addr == `LSG_OFF_STATUS) begin
         // Bits 7:5 stay zero
         rd_nxt[`LSG_ST_LINK_LOST] = link_lost[sel];
         rd_nxt[`LSG_ST_BIST_ERR]  = bist_err[sel];
         rd_nxt[`LSG_ST_TMDS_CLK]  = tmds_clk_ok_r;
         rd_nxt[`LSG_ST_NORM_ERR]  = norm_err[sel];
         rd_nxt[`LSG_ST_LINK_DET]  = link_up[sel];
      end else if (reg_addr == `LSG_OFF_PIN0_CFG) begin
         rd_nxt[`LSG_CFG_REV_HI:`LSG_CFG_REV_LO] = `LSG_REVISION_ID;
         rd_nxt[`LSG_CFG_OUT_VAL] = sel ? pin_outval_r[1]
                                        : pin_outval_r[0];
         rd_nxt[`LSG_CFG_MODE_HI:`LSG_CFG_MODE_LO] =
            sel ? pin_mode_r[1] : pin_mode_r[0];
      end else begin
         // Unmapped addresses read as zero
         rd_nxt = 8'h00;
      end
   end

   // ============================================================
   // Read data register
   // Read data stays until the next read so slow bus logic can fetch it
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rd_data_r  <= 8'h00;
         reg_rd_valid_r <= 1'b0;
      end else begin
         // Valid pulses once per read strobe
         reg_rd_valid_r <= reg_rd_en;
         if (reg_rd_en) begin
            reg_rd_data_r <= rd_nxt;
         end
      end
   end

endmodule // lsg_link_status_gpio_regs

`default_nettype wire

/* File: testbench/lsg_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lsg_map.vh"

// ============================================================
// Port checks for the link status and pin register bank
module lsg_checker (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       resetn,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr_en,
   input wire logic [7:0] reg_wr_data,
   input wire logic       reg_rd_en,
   input wire logic [7:0] reg_rd_data_r,
   input wire logic       reg_rd_valid_r,
   // Controls and link side
   input wire logic       second_port_select,
   input wire logic [1:0] link_det_pin,
   input wire logic       tmds_clk_det_pin,
   // Pins and live link state
   input wire logic       pin_zero_out_r,
   input wire logic       pin_zero_oe_r,
   input wire logic       second_port_pin_zero_out_r,
   input wire logic       second_port_pin_zero_oe_r,
   input wire logic [1:0] link_up_out_r
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   wire logic rd_st = reg_rd_en && reg_addr == `LSG_OFF_STATUS;
   wire logic rd_cfg = reg_rd_en && reg_addr == `LSG_OFF_PIN0_CFG;
   wire logic wr_cfg = reg_wr_en && reg_addr == `LSG_OFF_PIN0_CFG;

   property p_rd_pulse;
      reg_rd_en |=> reg_rd_valid_r ##1 (reg_rd_valid_r == $past(reg_rd_en));
   endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read valid is not a single pulse after the read");
   property p_unmapped;
      reg_rd_en && (reg_addr < 8'h0a || reg_addr > 8'h0d)
         |=> reg_rd_data_r == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned nonzero data");
   property p_rev;
      rd_cfg |=> reg_rd_data_r[7:4] == `LSG_REVISION_ID;
   endproperty
   a_rev: assert property (p_rev)
      else $error("revision nibble wrong");
   property p_hiz;
      wr_cfg && !second_port_select && !reg_wr_data[0] ##1 !reg_wr_en
         |=> !pin_zero_oe_r;
   endproperty
   a_hiz: assert property (p_hiz)
      else $error("pin driven in a high impedance mode");
   property p_local;
      wr_cfg && !second_port_select
         && reg_wr_data[2:0] == `LSG_MODE_OUT_LOCAL ##1 !reg_wr_en
         |=> pin_zero_oe_r && pin_zero_out_r == $past(reg_wr_data[3], 2);
   endproperty
   a_local: assert property (p_local)
      else $error("local output value not on the pin");
   property p_sel_pin;
      wr_cfg && second_port_select
         && reg_wr_data[2:0] == `LSG_MODE_OUT_LOCAL ##1 !reg_wr_en
         |=> second_port_pin_zero_oe_r
            && second_port_pin_zero_out_r == $past(reg_wr_data[3], 2);
   endproperty
   a_sel_pin: assert property (p_sel_pin)
      else $error("second port pin not configured by selected write");
   // Six samples cover the three-stage synchroniser, the filter update and the output register
   property p_link_up;
      link_det_pin[0] [*6] |-> link_up_out_r[0];
   endproperty
   a_link_up: assert property (p_link_up)
      else $error("link state not up with detect held high");
   property p_link_dn;
      !link_det_pin[0] [*6] |-> !link_up_out_r[0];
   endproperty
   a_link_dn: assert property (p_link_dn)
      else $error("link state not down with detect held low");
   property p_tmds;
      tmds_clk_det_pin [*6] ##0 rd_st |=> reg_rd_data_r[2];
   endproperty
   a_tmds: assert property (p_tmds)
      else $error("input clock status not set");
endmodule // lsg_checker

bind lsg_link_status_gpio_regs lsg_checker u_chk (
   .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
   .reg_rd_en(reg_rd_en), .reg_rd_data_r(reg_rd_data_r),
   .reg_rd_valid_r(reg_rd_valid_r),
   .second_port_select(second_port_select), .link_det_pin(link_det_pin),
   .tmds_clk_det_pin(tmds_clk_det_pin), .pin_zero_out_r(pin_zero_out_r),
   .pin_zero_oe_r(pin_zero_oe_r),
   .second_port_pin_zero_out_r(second_port_pin_zero_out_r),
   .second_port_pin_zero_oe_r(second_port_pin_zero_oe_r),
   .link_up_out_r(link_up_out_r)
);
`default_nettype wire

/* File: testbench/lsg_remote_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Remote end: link detect and back-channel frames per port
module lsg_remote_model (
   // Clock
   input  wire logic       core_clk,
   // Lines towards the bank
   output var  logic [1:0] link_det_pin,
   output var  logic [1:0] frame_crc_err,
   output var  logic [1:0] remote_pin_valid,
   output var  logic [1:0] remote_pin_value
);
   initial begin
      link_det_pin = 2'h0;
      frame_crc_err = 2'h0;
      remote_pin_valid = 2'h0;
      remote_pin_value = 2'h0;
   end

   task automatic set_link(input int p, input logic up);
      link_det_pin[p] = up;
   endtask

   task automatic frame(input int p, input logic bad, input logic val);
      @(posedge core_clk);
      #1;
      remote_pin_valid[p] = 1'b1;
      remote_pin_value[p] = val;
      frame_crc_err[p] = bad;
      @(posedge core_clk);
      #1;
      remote_pin_valid[p] = 1'b0;
      frame_crc_err[p] = 1'b0;
      // Stale between frames, so show the inverse, never the old value
      remote_pin_value[p] = ~val;
   endtask
endmodule // lsg_remote_model
`default_nettype wire

/* File: testbench/test_lsg_link_status_gpio_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lsg_map.vh"

// ============================================================
// Register-level bench
module test_lsg_link_status_gpio_regs;
   logic            core_clk = 1'b0;
   logic            resetn = 1'b0;
   logic [7:0]      reg_addr = 8'h00;
   logic [7:0]      reg_wr_data = 8'h00;
   logic            reg_wr_en = 1'b0;
   logic            reg_rd_en = 1'b0;
   logic            sel = 1'b0;
   logic            crc_rst = 1'b0;
   logic            tmds = 1'b0;
   logic            pin_in = 1'b0;
   logic            pin1_in = 1'b0;
   logic [1:0]      restart = 2'h0;
   logic [1:0]      bist = 2'h0;
   wire logic [1:0] det, err, rvld, rval, lvl, up;
   wire logic [7:0] rd_data;
   wire logic       rd_vld, p0_out, p0_oe, p1_out, p1_oe;
   int              failures = 0;
   int              total_checks = 0;

   always #4 core_clk = ~core_clk;

   lsg_remote_model rem (.core_clk(core_clk), .link_det_pin(det),
      .frame_crc_err(err), .remote_pin_valid(rvld), .remote_pin_value(rval));

   lsg_link_status_gpio_regs dut (.core_clk(core_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
      .reg_rd_en(reg_rd_en), .reg_rd_data_r(rd_data), .reg_rd_valid_r(rd_vld),
      .second_port_select(sel), .crc_err_reset(crc_rst),
      .bist_restart(restart), .link_det_pin(det), .frame_crc_err(err),
      .bist_active(bist), .remote_pin_valid(rvld), .remote_pin_value(rval),
      .tmds_clk_det_pin(tmds), .pin_zero_in(pin_in),
      .pin_zero_out_r(p0_out), .pin_zero_oe_r(p0_oe),
      .second_port_pin_zero_in(pin1_in), .second_port_pin_zero_out_r(p1_out),
      .second_port_pin_zero_oe_r(p1_oe), .pin_level_to_remote_r(lvl),
      .link_up_out_r(up));

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      reg_addr = a;
      reg_wr_data = d;
      reg_wr_en = 1'b1;
      cyc(1);
      reg_wr_en = 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      int n;
      cyc(1);
      reg_addr = a;
      reg_rd_en = 1'b1;
      cyc(1);
      reg_rd_en = 1'b0;
      n = 0;
      while (rd_vld !== 1'b1 && n < 8) begin
         cyc(1);
         n++;
      end
      if (n == 8) begin
         failures++;
         report_and_stop();
      end else begin
         chk(rd_data, exp);
      end
   endtask
   task automatic pin0(input logic [1:0] exp);
      chk({6'h00, p0_oe, p0_out}, {6'h00, exp});
   endtask
   task automatic tend(input string name);
      $display("test %s done, failures %0d", name, failures);
   endtask

   initial begin
      cyc(8);
      resetn = 1'b1;
      wr(8'h0a, 8'hff);
      wr(8'h0e, 8'hff);
      rdc(8'h0a, 8'h00);
      rdc(8'h0b, 8'h00);
      rdc(8'h0c, 8'h00);
      rdc(8'h0d, {`LSG_REVISION_ID, 4'h0});
      rdc(8'h0e, 8'h00);
      tend("reset");
      rem.set_link(0, 1'b1);
      rem.set_link(1, 1'b1);
      tmds = 1'b1;
      cyc(8);
      rdc(8'h0c, 8'h05);
      chk({6'h00, up}, 8'h03);
      repeat (3) rem.frame(0, 1'b1, 1'b0);
      sel = 1'b1;
      rem.frame(1, 1'b1, 1'b0);
      rdc(8'h0a, 8'h01);
      rdc(8'h0c, 8'h07);
      bist[1] = 1'b1;
      rem.frame(1, 1'b1, 1'b0);
      rdc(8'h0c, 8'h0f);
      restart = 2'h2;
      cyc(1);
      restart = 2'h0;
      bist = 2'h0;
      rdc(8'h0c, 8'h07);
      sel = 1'b0;
      rdc(8'h0c, 8'h07);
      rdc(8'h0a, 8'h03);
      tend("errors");
      // Carry into the high byte: 3 + 256 gives 0x0103
      repeat (256) rem.frame(0, 1'b1, 1'b0);
      rdc(8'h0a, 8'h03);
      rdc(8'h0b, 8'h01);
      crc_rst = 1'b1;
      cyc(1);
      crc_rst = 1'b0;
      rdc(8'h0a, 8'h00);
      rdc(8'h0b, 8'h00);
      rdc(8'h0c, 8'h05);
      tend("counter");
      rem.frame(0, 1'b1, 1'b0);
      bist[0] = 1'b1;
      rem.frame(0, 1'b1, 1'b0);
      bist = 2'h0;
      rdc(8'h0c, 8'h0f);
      rem.set_link(0, 1'b0);
      cyc(8);
      rdc(8'h0c, 8'h14);
      chk({6'h00, up}, 8'h02);
      rem.set_link(0, 1'b1);
      cyc(8);
      rdc(8'h0c, 8'h15);
      crc_rst = 1'b1;
      cyc(1);
      crc_rst = 1'b0;
      rdc(8'h0c, 8'h05);
      tend("link loss");
      wr(8'h0d, 8'h09);
      cyc(2);
      pin0(2'b11);
      rdc(8'h0d, {`LSG_REVISION_ID, 4'h9});
      wr(8'h0d, 8'h0e);
      cyc(2);
      pin0(2'b00);
      wr(8'h0d, 8'h03);
      pin_in = 1'b1;
      cyc(8);
      chk({6'h00, p0_oe, lvl[0]}, 8'h01);
      wr(8'h0d, 8'h05);
      rem.frame(0, 1'b0, 1'b1);
      cyc(2);
      pin0(2'b11);
      rem.set_link(0, 1'b0);
      cyc(8);
      pin0(2'b11);
      rem.set_link(0, 1'b1);
      cyc(8);
      wr(8'h0d, 8'h0f);
      rem.frame(0, 1'b0, 1'b0);
      cyc(2);
      pin0(2'b10);
      rem.set_link(0, 1'b0);
      cyc(8);
      pin0(2'b11);
      sel = 1'b1;
      wr(8'h0d, 8'h01);
      cyc(2);
      chk({6'h00, p1_oe, p1_out}, 8'h02);
      rdc(8'h0d, {`LSG_REVISION_ID, 4'h1});
      wr(8'h0d, 8'h03);
      pin1_in = 1'b1;
      cyc(8);
      chk({6'h00, p1_oe, lvl[1]}, 8'h01);
      sel = 1'b0;
      rdc(8'h0d, {`LSG_REVISION_ID, 4'hf});
      tend("pins");
      report_and_stop();
   end
endmodule // test_lsg_link_status_gpio_regs
`default_nettype wire
